// [shared/ispci_pkg.sv]
// Purpose: shared constants, types and helpers for the serial flash command interpreter
// Assumes: 125 MHz system clock on both ends
// Notes: timing counts are derived from the figures in their own units
package ispci_pkg;
	// command opcodes (first byte)
	localparam logic [7:0] OP_INIT1 = 8'h1A;
	localparam logic [7:0] OP_INIT12 = 8'h9E;
	localparam logic [7:0] OP_CONF1 = 8'h01;
	localparam logic [7:0] OP_CONF2 = 8'h91;
	localparam logic [7:0] OP_SEG = 8'hC6;
	localparam logic [7:0] OP_ADDR = 8'hC8;
	localparam logic [7:0] OP_BUSY = 8'hC5;
	localparam logic [7:0] OP_RUN = 8'hC2;
	localparam logic [7:0] OP_DATA_H = 8'hD2;
	localparam logic [7:0] OP_DATA_L = 8'hCA;
	localparam logic [7:0] OP_EXP_H = 8'hE4;
	localparam logic [7:0] OP_EXP_L = 8'hE2;
	localparam logic [7:0] OP_RESULT = 8'hE7;
	localparam logic [7:0] OP_CLR3 = 8'hE6;
	// argument values
	localparam logic [15:0] INIT1_ARG = 16'h0008;
	localparam logic [15:0] INIT12_ARG = 16'hFFFF;
	localparam logic [15:0] CLR3_ARG = 16'h0003;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [7:0] BYTE_FF = 8'hFF;
	localparam logic [7:0] BYTE_00 = 8'h00;
	localparam logic [7:0] RUN_BLOCK = 8'h05;
	localparam logic [7:0] RUN_CHIP = 8'h06;
	localparam logic [7:0] RUN_PROG = 8'h04;
	localparam logic [7:0] RUN_VERIFY = 8'h02;
	// read answers
	localparam logic [15:0] CONF1_RESP = 16'h06C0;
	localparam logic [15:0] CONF2_RESP = 16'h0000;
	localparam logic [7:0] BUSY_IDLE = 8'h00;
	localparam logic [7:0] BUSY_YES = 8'h01;
	localparam logic [7:0] BUSY_TAIL = 8'h1F;
	// frame layout
	localparam logic [4:0] CMD_BITS = 5'h18;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam int SEG_W = 5;
	// timing figures and derived cycle counts
	localparam int CLK_MHZ = 125;
	localparam int TIMEOUT_MS = 800;
	localparam int INTERVAL_US = 80;
	localparam int RETRY_US = 200;
	localparam int BUSY_US = 80;
	localparam int LINK_HALF_NS = 250;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int INTERVAL_CYC = INTERVAL_US * CLK_MHZ;
	localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
	localparam int BUSY_CYC = BUSY_US * CLK_MHZ;
	localparam int HALF_CYC = (LINK_HALF_NS * CLK_MHZ) / 1000;

	typedef enum logic [1:0] {FOP_BLOCK_ERASE, FOP_CHIP_ERASE, FOP_PROGRAM, FOP_VERIFY} ispci_fop_t;

	// opcodes whose second and third bytes are read back
	function automatic logic is_read_op(input logic [7:0] op);
		return op == OP_CONF1 || op == OP_CONF2 || op == OP_BUSY || op == OP_RESULT;
	endfunction
endpackage

// [shared/ispci_link_if.sv]
// Purpose: two-wire serial link plus frame strobe between programmer and device
// Assumes: data line has a pull-up; at most one end enables its driver
// Notes: the shared data level is resolved here from both enables
`timescale 1ns/1ps
interface ispci_link_if;
	logic sclk;
	logic isp_frame_strobe_n;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	wire sda;

	// pulled high when nobody drives
	assign sda = host_sda_oe ? host_sda_out : (dev_sda_oe ? dev_sda_out : 1'b1);

	modport host(output sclk, output isp_frame_strobe_n, output host_sda_out, output host_sda_oe, input sda);
	modport device(input sclk, input isp_frame_strobe_n, input sda, output dev_sda_out, output dev_sda_oe);
endinterface

// [design/ispci_device.sv]
// Purpose: device end of the in_system_programming command interpreter
// Assumes: link pins are asynchronous and pass two flip-flops; flash side is on clk
// Notes: commands other than reads take effect at the end of the next frame
`timescale 1ns/1ps
module ispci_device #(
	parameter int TIMEOUT_CYC = ispci_pkg::TIMEOUT_CYC
) (
	input logic clk,
	input logic rst_n,
	ispci_link_if.device link,
	input logic flash_busy,
	input logic verify_done,
	input logic verify_match,
	output logic flash_start,
	output ispci_pkg::ispci_fop_t flash_op,
	output logic [ispci_pkg::SEG_W-1:0] flash_seg,
	output logic [15:0] flash_addr,
	output logic flash_data_area,
	output logic [31:0] flash_wdata,
	output logic [31:0] flash_expect,
	output logic mode_active,
	output logic setup_done
);
	// refuse a timeout the idle counter cannot serve
	if (TIMEOUT_CYC < 2) begin : bad_timeout
		$error("timeout count too small");
	end

	// pin synchronisers and edge history
	logic sclk_s1, sclk_s2, sclk_q;
	logic stb_s1, stb_s2, stb_q;
	logic sda_s1, sda_s2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_q <= 1'b0;
			stb_s1 <= 1'b1;
			stb_s2 <= 1'b1;
			stb_q <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			sclk_s1 <= link.sclk;
			sclk_s2 <= sclk_s1;
			sclk_q <= sclk_s2;
			stb_s1 <= link.isp_frame_strobe_n;
			stb_s2 <= stb_s1;
			stb_q <= stb_s2;
			sda_s1 <= link.sda;
			sda_s2 <= sda_s1;
		end
	end

	wire in_frame = ~stb_s2;
	wire sclk_rise = sclk_s2 & ~sclk_q & in_frame;
	wire sclk_fall = ~sclk_s2 & sclk_q & in_frame;
	wire frame_end = stb_s2 & ~stb_q;

	// receive shifter
	logic [4:0] bit_cnt;
	logic [23:0] rx;
	logic rd_op;
	logic [15:0] tx;
	wire rx_take = sclk_rise && bit_cnt < ispci_pkg::CMD_BITS;
	wire [7:0] first_byte = {rx[6:0], sda_s2};
	wire first_done = rx_take && bit_cnt == ispci_pkg::BYTE_BITS - 5'h01;
	wire read_slot = rd_op && bit_cnt >= ispci_pkg::BYTE_BITS;
	wire cmd_ok = bit_cnt == ispci_pkg::CMD_BITS;
	wire [7:0] c_op = rx[23:16];

	// verify history
	logic cur_ok;
	logic hist_fail;
	wire [7:0] result_byte = {6'h00, ~hist_fail, cur_ok};

	// answer chosen once the opcode is in
	wire [7:0] busy_byte = flash_busy ? ispci_pkg::BUSY_YES : ispci_pkg::BUSY_IDLE;
	wire [15:0] answer = (first_byte == ispci_pkg::OP_CONF1) ? ispci_pkg::CONF1_RESP :
		(first_byte == ispci_pkg::OP_CONF2) ? ispci_pkg::CONF2_RESP :
		(first_byte == ispci_pkg::OP_BUSY) ? {busy_byte, ispci_pkg::BUSY_TAIL} :
		{ispci_pkg::BYTE_00, result_byte};

	// bit counter and msb-first shift in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 5'h00;
			rx <= 24'h000000;
		end else if (!in_frame) begin
			bit_cnt <= 5'h00;
		end else if (rx_take) begin
			bit_cnt <= bit_cnt + 5'h01;
			rx <= {rx[22:0], sda_s2};
		end
	end

	// read bytes driven after each falling clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_op <= 1'b0;
			tx <= 16'h0000;
			link.dev_sda_out <= 1'b1;
			link.dev_sda_oe <= 1'b0;
		end else if (!in_frame) begin
			rd_op <= 1'b0;
			link.dev_sda_oe <= 1'b0;
		end else if (first_done) begin
			rd_op <= ispci_pkg::is_read_op(first_byte);
			tx <= answer;
		end else if (sclk_fall && read_slot) begin
			link.dev_sda_out <= tx[15];
			link.dev_sda_oe <= 1'b1;
			tx <= {tx[14:0], 1'b0};
		end
	end

	// pending command, run when the next frame ends
	logic [23:0] pend;
	logic pend_valid;
	wire take = frame_end && cmd_ok && mode_active;
	wire exec = take && pend_valid;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 24'h000000;
			pend_valid <= 1'b0;
		end else if (take) begin
			pend <= rx;
			pend_valid <= ~ispci_pkg::is_read_op(c_op);
		end
	end

	// decode of the pending command
	wire [7:0] p_op = pend[23:16];
	wire [7:0] p_b2 = pend[15:8];
	wire [7:0] p_b3 = pend[7:0];
	wire [15:0] p_arg = pend[15:0];
	wire b2_ff = p_b2 == ispci_pkg::BYTE_FF;
	wire d_seg = exec && p_op == ispci_pkg::OP_SEG && p_b2 == ispci_pkg::BYTE_00;
	wire d_addr = exec && p_op == ispci_pkg::OP_ADDR;
	wire d_data_h = exec && p_op == ispci_pkg::OP_DATA_H;
	wire d_data_d = exec && p_op == ispci_pkg::OP_DATA_L && b2_ff;
	wire d_data_l = exec && p_op == ispci_pkg::OP_DATA_L && !b2_ff;
	wire d_exp_d = exec && p_op == ispci_pkg::OP_EXP_H && b2_ff;
	wire d_exp_h = exec && p_op == ispci_pkg::OP_EXP_H && !b2_ff;
	wire d_exp_l = exec && p_op == ispci_pkg::OP_EXP_L;
	wire d_init12 = exec && p_op == ispci_pkg::OP_INIT12 && p_arg == ispci_pkg::INIT12_ARG;
	wire d_run = exec && p_op == ispci_pkg::OP_RUN && p_b2 == ispci_pkg::BYTE_00;
	wire run_blk = p_b3 == ispci_pkg::RUN_BLOCK;
	wire run_chip = p_b3 == ispci_pkg::RUN_CHIP;
	wire run_prog = p_b3 == ispci_pkg::RUN_PROG;
	wire run_ver = p_b3 == ispci_pkg::RUN_VERIFY;
	wire run_ok = d_run && (run_blk || run_chip || run_prog || run_ver);
	wire clr1 = exec && p_op == ispci_pkg::OP_DATA_H && p_arg == ispci_pkg::ZERO16;
	wire clr2 = exec && p_op == ispci_pkg::OP_DATA_L && p_arg == ispci_pkg::ZERO16;
	wire clr3 = exec && p_op == ispci_pkg::OP_CLR3 && p_arg == ispci_pkg::CLR3_ARG;
	wire keep_exec = exec && ((p_op == ispci_pkg::OP_INIT1 && p_arg == ispci_pkg::INIT1_ARG) ||
		p_op == ispci_pkg::OP_EXP_H);
	wire keep_poll = take && c_op == ispci_pkg::OP_BUSY;

	// segment, address and data area selection
	logic [15:0] addr;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_seg <= '0;
			addr <= 16'h0000;
			flash_data_area <= 1'b0;
		end else begin
			if (d_seg) flash_seg <= p_b3[ispci_pkg::SEG_W-1:0];
			if (d_addr) addr <= p_arg;
			if (d_data_d || d_exp_d) flash_data_area <= 1'b1;
			else if (d_data_h || d_data_l || d_exp_h || d_exp_l) flash_data_area <= 1'b0;
		end
	end

	// program data and expected data words
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_wdata <= 32'h00000000;
			flash_expect <= 32'h00000000;
		end else begin
			if (d_data_h) flash_wdata[31:16] <= p_arg;
			if (d_data_l) flash_wdata[15:0] <= p_arg;
			if (d_data_d) flash_wdata <= {24'h000000, p_b3};
			if (d_exp_h) flash_expect[31:16] <= p_arg;
			if (d_exp_l) flash_expect[15:0] <= p_arg;
			if (d_exp_d) flash_expect <= {24'h000000, p_b3};
		end
	end

	// operation start; code area addresses forced to a word boundary
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_start <= 1'b0;
			flash_op <= ispci_pkg::FOP_BLOCK_ERASE;
			flash_addr <= 16'h0000;
		end else begin
			flash_start <= run_ok;
			if (run_ok) begin
				flash_op <= run_blk ? ispci_pkg::FOP_BLOCK_ERASE : run_chip ? ispci_pkg::FOP_CHIP_ERASE :
					run_prog ? ispci_pkg::FOP_PROGRAM : ispci_pkg::FOP_VERIFY;
				flash_addr <= flash_data_area ? addr : {addr[15:2], 2'b00};
			end
		end
	end

	// history clear sequence tracker
	logic [1:0] clr_stage;
	wire clr_hit = clr3 && clr_stage == 2'h2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_stage <= 2'h0;
		end else if (exec) begin
			clr_stage <= clr1 ? 2'h1 : (clr2 && clr_stage == 2'h1) ? 2'h2 : 2'h0;
		end
	end

	// compare outcome and sticky mismatch history, a new miss beats a clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ok <= 1'b0;
			hist_fail <= 1'b0;
		end else begin
			if (verify_done) cur_ok <= verify_match;
			if (verify_done && !verify_match) hist_fail <= 1'b1;
			else if (clr_hit) hist_fail <= 1'b0;
		end
	end

	// inactivity timeout and setup flag
	logic [31:0] idle_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt <= 32'h00000000;
			mode_active <= 1'b1;
			setup_done <= 1'b0;
		end else begin
			if (keep_exec || keep_poll || !mode_active) idle_cnt <= 32'h00000000;
			else idle_cnt <= idle_cnt + 32'h00000001;
			if (idle_cnt == 32'(TIMEOUT_CYC - 1)) mode_active <= 1'b0;
			if (d_init12) setup_done <= 1'b1;
		end
	end
endmodule

// [design/ispci_host.sv]
// Purpose: programmer end, sends three-byte commands and gathers read bytes
// Assumes: user keeps command order and spacing through cmd_retry and gap settings
// Notes: serial clock made here by a divider; idles low between frames
`timescale 1ns/1ps
module ispci_host #(
	parameter int HALF_CYC = ispci_pkg::HALF_CYC,
	parameter int GAP_CYC = ispci_pkg::BUSY_CYC,
	parameter int RETRY_CYC = ispci_pkg::RETRY_CYC,
	parameter int INTERVAL_CYC = ispci_pkg::INTERVAL_CYC
) (
	input logic clk,
	input logic rst_n,
	ispci_link_if.host link,
	input logic cmd_valid,
	input logic [23:0] cmd_word,
	input logic cmd_retry,
	output logic cmd_ready,
	output logic resp_valid,
	output logic [15:0] resp_data,
	output logic interval_lapsed
);
	// refuse timings the divider and wait counters cannot serve
	if (HALF_CYC < 4 || GAP_CYC < 1 || RETRY_CYC < 1 || INTERVAL_CYC < 1) begin : bad_timing
		$error("host timing parameters too small");
	end

	typedef enum logic [2:0] {H_IDLE, H_GAP, H_LOW, H_HIGH, H_DONE} ispci_hst_t;
	ispci_hst_t st;
	logic [31:0] tmr;
	logic [31:0] wait_len;
	logic [31:0] idle_tmr;
	logic [4:0] bit_idx;
	logic [23:0] sh;
	logic rd;
	logic sda_s1, sda_s2;

	wire half_done = tmr == 32'(HALF_CYC - 1);
	wire last_bit = bit_idx == ispci_pkg::CMD_BITS - 5'h01;
	wire next_read = rd && bit_idx + 5'h01 >= ispci_pkg::BYTE_BITS;

	// data line synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			sda_s1 <= link.sda;
			sda_s2 <= sda_s1;
		end
	end

	// time since last frame, flags a missed interval
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_tmr <= 32'h00000000;
			interval_lapsed <= 1'b0;
		end else begin
			idle_tmr <= (st == H_IDLE || st == H_GAP) ? idle_tmr + 32'h00000001 : 32'h00000000;
			interval_lapsed <= idle_tmr >= 32'(INTERVAL_CYC);
		end
	end

	// frame sequencer, msb first, read bytes sampled before falling clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= H_IDLE;
			tmr <= 32'h00000000;
			wait_len <= 32'h00000000;
			bit_idx <= 5'h00;
			sh <= 24'h000000;
			rd <= 1'b0;
			cmd_ready <= 1'b1;
			resp_valid <= 1'b0;
			resp_data <= 16'h0000;
			link.sclk <= 1'b0;
			link.isp_frame_strobe_n <= 1'b1;
			link.host_sda_out <= 1'b1;
			link.host_sda_oe <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			tmr <= tmr + 32'h00000001;
			unique case (st)
				H_IDLE: begin
					if (cmd_valid) begin
						sh <= cmd_word;
						rd <= ispci_pkg::is_read_op(cmd_word[23:16]);
						wait_len <= cmd_retry ? 32'(RETRY_CYC) : 32'(GAP_CYC);
						cmd_ready <= 1'b0;
						tmr <= 32'h00000000;
						st <= H_GAP;
					end
				end
				H_GAP: begin
					if (tmr >= wait_len) begin
						link.isp_frame_strobe_n <= 1'b0;
						link.host_sda_out <= sh[23];
						link.host_sda_oe <= 1'b1;
						bit_idx <= 5'h00;
						tmr <= 32'h00000000;
						st <= H_LOW;
					end
				end
				H_LOW: begin
					if (half_done) begin
						link.sclk <= 1'b1;
						tmr <= 32'h00000000;
						st <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (half_done) begin
						link.sclk <= 1'b0;
						tmr <= 32'h00000000;
						if (rd && bit_idx >= ispci_pkg::BYTE_BITS) resp_data <= {resp_data[14:0], sda_s2};
						if (last_bit) begin
							link.host_sda_oe <= 1'b0;
							st <= H_DONE;
						end else begin
							sh <= {sh[22:0], 1'b0};
							link.host_sda_out <= sh[22];
							link.host_sda_oe <= ~next_read;
							bit_idx <= bit_idx + 5'h01;
							st <= H_LOW;
						end
					end
				end
				H_DONE: begin
					if (half_done) begin
						link.isp_frame_strobe_n <= 1'b1;
						resp_valid <= rd;
						cmd_ready <= 1'b1;
						st <= H_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// [bench/ispci_monitor.sv]
// Purpose: watches the serial link between the programmer and device ends
// Assumes: both ends share one system clock; link clock made by the host divider
// Notes: half period of the link clock is handed in as a parameter
`timescale 1ns/1ps
module ispci_monitor #(
	parameter int HALF_CYC = 10
) (
	input logic clk,
	input logic rst_n,
	input logic sclk,
	input logic isp_frame_strobe_n,
	input logic host_sda_out,
	input logic host_sda_oe,
	input logic dev_sda_out,
	input logic dev_sda_oe,
	input wire sda
);
	logic sclk_q;
	logic [4:0] rise_cnt;
	logic [7:0] op_sh;
	// edge of the link clock and opcodes that read back
	wire sclk_rise = sclk && !sclk_q;
	wire rd_op = op_sh == 8'h01 || op_sh == 8'h91 || op_sh == 8'hC5 || op_sh == 8'hE7;

	// count link clock rises and gather the opcode of a frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			rise_cnt <= 5'h00;
			op_sh <= 8'h00;
		end else begin
			sclk_q <= sclk;
			rise_cnt <= isp_frame_strobe_n ? 5'h00 : rise_cnt + {4'h0, sclk_rise};
			op_sh <= (sclk_rise && rise_cnt < 5'h08) ? {op_sh[6:0], sda} : op_sh;
		end
	end

	default clocking mon_cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sclk_idle_low_a: assert property (isp_frame_strobe_n |-> !sclk)
		else $error("link clock moves outside a frame");
	sclk_half_a: assert property ($rose(sclk) |-> ##HALF_CYC $fell(sclk))
		else $error("link clock high half has wrong length");
	frame_bits_a: assert property ($rose(isp_frame_strobe_n) |-> rise_cnt == 5'h18)
		else $error("frame does not hold three bytes");
	opcode_drive_a: assert property ($fell(isp_frame_strobe_n) |-> host_sda_oe)
		else $error("host not driving at frame start");
	one_driver_a: assert property (!(host_sda_oe && dev_sda_oe))
		else $error("both ends drive the data line");
	bit_steady_a: assert property ((sclk && $past(sclk)) |-> $stable(sda))
		else $error("data moves while link clock is high");
	dev_quiet_op_a: assert property ((!isp_frame_strobe_n && rise_cnt < 5'h08) |-> !dev_sda_oe)
		else $error("device drives during the opcode byte");
	dev_reads_only_a: assert property ((!isp_frame_strobe_n && rise_cnt > 5'h08 && !rd_op) |-> !dev_sda_oe)
		else $error("device answers a command that reads nothing");
	dev_release_a: assert property ($rose(isp_frame_strobe_n) |-> ##[0:8] !dev_sda_oe)
		else $error("device holds the data line after the frame");
endmodule

// [bench/ispci_tb.sv]
// Purpose: self-checking bench for the host and device ends joined over the link
// Assumes: shortened link, gap and timeout counts; the flash is a small model here
// Notes: a device check in a row sees the command of the row before it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module ispci_tb;
	localparam int TMO = 20000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_retry = 1'b0;
	logic [23:0] cmd_word = 24'h000000;
	logic verify_done = 1'b0;
	logic verify_match = 1'b0;
	logic cmd_ready, resp_valid, interval_lapsed, flash_start, flash_data_area, mode_active, setup_done, setup2;
	logic [15:0] resp_data, flash_addr;
	logic [4:0] flash_seg;
	logic [31:0] flash_wdata, flash_expect;
	logic [23:0] wire_word = 24'h000000;
	ispci_pkg::ispci_fop_t flash_op;
	int failures = 0;
	int n_checks = 0;
	int busy_cnt = 0;
	int n_starts = 0;
	int wire_bits = 0;
	int n_resp = 0;
	int n_rd = 0;
	wire flash_busy = busy_cnt != 0;
	// rows: command, answer, match and check kind, expected output
	logic [75:0] rows [0:38] = '{
		76'h9EFFFF_0000_0_00000000, 76'h010000_06C0_5_00000001, 76'h910000_0000_0_00000000,
		76'hC6001F_0000_0_00000000, 76'hC81236_0000_1_0000001F, 76'hD2A1B2_0000_0_00000000,
		76'hCAC3D4_0000_0_00000000, 76'hC20004_0000_3_A1B2C3D4, 76'hC50000_001F_6_00000002,
		76'hC50000_011F_2_00001234, 76'hE4A1B2_0000_0_00000000, 76'hE2C3D4_0000_0_00000000,
		76'hC20002_0000_C_A1B2C3D4, 76'hC50000_001F_E_00000003, 76'hC50000_011F_8_00000000,
		76'hE70000_0003_8_00000000, 76'hC20002_0000_0_00000000, 76'hC50000_001F_0_00000000,
		76'hC50000_011F_0_00000000, 76'hE70000_0000_0_00000000, 76'hC20002_0000_8_00000000,
		76'hC50000_001F_8_00000000, 76'hC50000_011F_8_00000000, 76'hE70000_0001_8_00000000,
		76'hD20000_0000_8_00000000, 76'hCA0000_0000_8_00000000, 76'hE60003_0000_8_00000000,
		76'hC20002_0000_8_00000000, 76'hC50000_001F_8_00000000, 76'hC50000_011F_8_00000000,
		76'hE70000_0003_8_00000000, 76'hC80010_0000_8_00000000, 76'hCAFF5A_0000_8_00000000,
		76'hE4FF77_0000_8_00000000, 76'hC20005_0000_F_00015A77, 76'hC50000_001F_E_00000000,
		76'hC50000_011F_8_00000000, 76'hC20006_0000_8_00000000, 76'hC50000_001F_E_00000001};

	ispci_link_if link ();
	ispci_link_if link2 ();
	ispci_host #(.HALF_CYC(10), .GAP_CYC(50), .RETRY_CYC(100), .INTERVAL_CYC(2000)) ispci_host_inst (.clk, .rst_n,
		.link(link.host), .cmd_valid, .cmd_word, .cmd_retry, .cmd_ready, .resp_valid, .resp_data, .interval_lapsed);
	ispci_device #(.TIMEOUT_CYC(TMO)) ispci_device_inst (.clk, .rst_n, .link(link.device), .flash_busy, .verify_done,
		.verify_match, .flash_start, .flash_op, .flash_seg, .flash_addr, .flash_data_area, .flash_wdata, .flash_expect,
		.mode_active, .setup_done);
	ispci_device #(.TIMEOUT_CYC(TMO)) ispci_device_inst2 (.clk, .rst_n, .link(link2.device), .flash_busy, .verify_done,
		.verify_match, .flash_start(), .flash_op(), .flash_seg(), .flash_addr(), .flash_data_area(), .flash_wdata(),
		.flash_expect(), .mode_active(), .setup_done(setup2));
	ispci_monitor #(.HALF_CYC(10)) ispci_monitor_inst (.clk, .rst_n, .sclk(link.sclk),
		.isp_frame_strobe_n(link.isp_frame_strobe_n), .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
		.dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

	always #4 clk = ~clk;

	// small flash: busy for a while after each start, compare ends with a pulse
	always @(negedge clk) begin
		verify_done <= busy_cnt == 1 && flash_op === ispci_pkg::FOP_VERIFY;
		busy_cnt <= flash_start ? 600 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
		n_starts <= n_starts + (flash_start === 1'b1);
		n_resp <= n_resp + (resp_valid === 1'b1);
	end

	// link bits as the device samples them
	always @(posedge link.sclk) begin
		wire_word <= {wire_word[22:0], link.sda};
		wire_bits <= wire_bits + 1;
	end

	task automatic close_out();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// one command through the host, back when it is idle again
	task automatic send(input logic [23:0] cmd);
		int k;
		k = 0;
		cmd_word = cmd;
		cmd_valid = 1'b1;
		wire_bits = 0;
		@(negedge clk);
		cmd_valid = 1'b0;
		while (cmd_ready !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		`CHK("ready", 1'b1, cmd_ready)
		repeat (8) @(negedge clk);
	endtask

	// frame of n bits driven by the bench on the second link
	task automatic bang(input logic [23:0] w, input int n);
		link2.isp_frame_strobe_n = 1'b0;
		link2.host_sda_oe = 1'b1;
		for (int b = n - 1; b >= 0; b--) begin
			link2.host_sda_out = w[b];
			repeat (10) @(negedge clk);
			link2.sclk = 1'b1;
			repeat (10) @(negedge clk);
			link2.sclk = 1'b0;
		end
		repeat (10) @(negedge clk);
		link2.isp_frame_strobe_n = 1'b1;
		link2.host_sda_oe = 1'b0;
		repeat (40) @(negedge clk);
	endtask

	initial begin
		#600000;
		failures++;
		close_out();
	end

	initial begin
		logic [75:0] r;
		logic [31:0] got;
		logic [23:0] ew;
		logic rd;
		link2.sclk = 1'b0;
		link2.isp_frame_strobe_n = 1'b1;
		link2.host_sda_out = 1'b1;
		link2.host_sda_oe = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		// short frame between a command and the next is dropped
		bang(24'h9EFFFF, 24);
		`CHK("held setup", 1'b0, setup2)
		bang(24'h7FFFFF, 23);
		`CHK("short frame", 1'b0, setup2)
		bang(24'hC6001F, 24);
		`CHK("setup done", 1'b1, setup2)
		// table of commands
		for (int i = 0; i < 39; i++) begin
			r = rows[i];
			verify_match = r[35];
			send(r[75:52]);
			rd = r[75:68] inside {8'h01, 8'h91, 8'hC5, 8'hE7};
			ew = rd ? {r[75:68], r[51:36]} : r[75:52];
			n_rd = n_rd + int'(rd);
			`CHK("link word", ew, wire_word)
			`CHK("link bits", 24, wire_bits)
			if (rd) `CHK("answer", r[51:36], resp_data)
			case (r[34:32])
				3'h1: got = {27'h0, flash_seg};
				3'h2: got = {16'h0, flash_addr};
				3'h3: got = flash_wdata;
				3'h4: got = flash_expect;
				3'h5: got = {31'h0, setup_done};
				3'h6: got = {30'h0, flash_op};
				default: got = {15'h0, flash_data_area, flash_wdata[7:0], flash_expect[7:0]};
			endcase
			if (r[34:32] != 3'h0) `CHK("device output", r[31:0], got)
		end
		`CHK("flash starts", 7, n_starts)
		`CHK("answer pulses", n_rd, n_resp)
		// poll with the retry wait, then fall silent
		cmd_retry = 1'b1;
		send(24'hC50000);
		`CHK("retry answer", 16'h011F, resp_data)
		`CHK("interval kept", 1'b0, interval_lapsed)
		repeat (2100) @(negedge clk);
		`CHK("interval lapsed", 1'b1, interval_lapsed)
		repeat (TMO - 2400) @(negedge clk);
		`CHK("mode kept", 1'b1, mode_active)
		repeat (600) @(negedge clk);
		`CHK("mode left", 1'b0, mode_active)
		// second reset brings the mode back
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("reset mode", 1'b1, mode_active)
		`CHK("reset setup", 1'b0, setup_done)
		`CHK("reset strobe", 1'b1, link.isp_frame_strobe_n)
		rst_n = 1'b1;
		cmd_retry = 1'b0;
		@(negedge clk);
		send(24'h010000);
		`CHK("answer after reset", 16'h06C0, resp_data)
		close_out();
	end
endmodule
